// [src/flash_pins_pkg.sv]
// Constants, types and helper functions for the serial flash pin front end.
package flash_pins_pkg;
  localparam int          BYTE_W       = 8;
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_BYTES   = 256;
  localparam int          PAGE_COUNT   = 65536;
  localparam logic [8:0]  PAGE_FULL    = 9'h100;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [1:0]  SRP_HW_LOCK  = 2'h1;
  localparam logic [7:0]  TX_IDLE_BYTE = 8'hff;
  localparam logic [23:0] SPAN_4K      = 24'h000fff;
  localparam logic [23:0] SPAN_32K     = 24'h007fff;
  localparam logic [23:0] SPAN_64K     = 24'h00ffff;
  localparam logic [23:0] SPAN_CHIP    = 24'hffffff;

  typedef enum logic [1:0] {
    LANE_OFF = 2'h0,
    LANE_X1  = 2'h1,
    LANE_X2  = 2'h2,
    LANE_X4  = 2'h3
  } lanes_e;

  typedef enum logic [1:0] {
    ERASE_4K   = 2'h0,
    ERASE_32K  = 2'h1,
    ERASE_64K  = 2'h2,
    ERASE_CHIP = 2'h3
  } erase_e;

  typedef enum logic [2:0] {
    FR_ARM  = 3'h1,
    FR_IDLE = 3'h2,
    FR_SEL  = 3'h4
  } frame_e;

  function automatic logic [3:0] lane_bits(input lanes_e l);
    case (l)
      LANE_X1: lane_bits = 4'h1;
      LANE_X2: lane_bits = 4'h2;
      LANE_X4: lane_bits = 4'h4;
      default: lane_bits = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input lanes_e l);
    case (l)
      LANE_X1: lane_oe = 4'h2;
      LANE_X2: lane_oe = 4'h3;
      LANE_X4: lane_oe = 4'hf;
      default: lane_oe = 4'h0;
    endcase
  endfunction

  function automatic logic [23:0] erase_span(input erase_e k);
    case (k)
      ERASE_4K:  erase_span = SPAN_4K;
      ERASE_32K: erase_span = SPAN_32K;
      ERASE_64K: erase_span = SPAN_64K;
      default:   erase_span = SPAN_CHIP;
    endcase
  endfunction
endpackage

// [src/flash_pin_front.sv]
// Pin-level front end of a multi-lane serial flash: select, shift, lanes, protect pin.
// Summary of operation
// - With select high every data output pin is released to high impedance.
// - Deselected with no internal cycle running the part sits in standby; select low makes it active.
// - No command is taken after reset until a falling edge of select has been seen.
// - Command, address and input data bits are sampled on rising serial clock edges.
// - Output bits change only on falling serial clock edges, in every lane width.
// - Dual and quad reads turn line zero into an output and drive two or four bits per falling edge.
// - Dual reads keep line one as an output and drive two bits per edge on lines one and zero.
// - Line zero is ignored whenever select is high.
// - The active low protect pin, with the status protect bits at the hardware lock value, blocks status writes.
// - With the quad enable bit set the protect function is off and the pin is data line two.
// - The array is 65,536 pages of 256 bytes and a page program takes one to 256 bytes.
// - Erase works only on 4, 32 or 64 kbyte blocks or on the whole chip.
// - While hold is low clock edges and input data are ignored and outputs float.
// - Hold pauses only the serial link and leaves running program or erase cycles alone.
`timescale 1ns/1ps
`default_nettype none
module flash_pin_front
  import flash_pins_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic                   data_line_zero_i,
  output logic                        data_line_zero_o,
  output logic                        data_line_zero_oe,
  input  wire logic                   data_line_one_i,
  output logic                        data_line_one_o,
  output logic                        data_line_one_oe,
  input  wire logic                   data_line_two_i,
  output logic                        data_line_two_o,
  output logic                        data_line_two_oe,
  input  wire logic                   data_line_three_i,
  output logic                        data_line_three_o,
  output logic                        data_line_three_oe,
  input  wire logic                   quad_enable_bit,
  input  wire logic [1:0]             status_protect_bits,
  input  wire logic                   sector_granularity_bit,
  input  wire logic                   top_bottom_select,
  input  wire logic                   block_protect_msb,
  input  wire logic                   block_protect_mid,
  input  wire logic                   block_protect_lsb,
  input  wire logic                   int_busy,
  input  wire flash_pins_pkg::lanes_e rx_lanes,
  input  wire flash_pins_pkg::lanes_e tx_lanes,
  output logic [7:0]                  rx_data,
  output logic                        rx_valid,
  input  wire logic                   rx_ready,
  output logic                        rx_buf_ready,
  output logic                        rx_overrun,
  input  wire logic [7:0]             tx_data,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  output logic                        standby,
  output logic                        selected,
  output logic                        frame_start,
  output logic                        status_write_ok,
  output logic                        array_hw_lock,
  input  wire logic [23:0]            addr_in,
  input  wire flash_pins_pkg::erase_e erase_kind,
  input  wire logic                   erase_go,
  output logic [23:0]                 erase_base,
  output logic [23:0]                 erase_last,
  input  wire logic                   prog_go,
  input  wire logic                   prog_byte,
  output logic [23:0]                 prog_addr,
  output logic [8:0]                  prog_count
);
  import flash_pins_pkg::*;

  // Serial clock domain, rising edge: configuration levels and receive shifter.
  logic       qe_s1_q;
  logic       qe_s2_q;
  lanes_e     rxl_s1_q;
  lanes_e     rxl_s2_q;
  lanes_e     txl_s1_q;
  lanes_e     txl_s2_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_byte_q;
  logic       rx_tgl_q;

  wire        hold_now = ~qe_s2_q & ~data_line_three_i;
  wire [3:0]  rx_din = {data_line_three_i, data_line_two_i,
                        data_line_one_i, data_line_zero_i};
  wire [3:0]  rx_n = lane_bits(rxl_s2_q);
  wire [3:0]  rx_sum = rx_cnt_q + rx_n;
  wire        rx_done = (rx_sum == BYTE_BITS);
  logic [7:0] rx_sh_d;

  always_comb begin
    case (rxl_s2_q)
      LANE_X2: rx_sh_d = {rx_sh_q[5:0], rx_din[1:0]};
      LANE_X4: rx_sh_d = {rx_sh_q[3:0], rx_din};
      default: rx_sh_d = {rx_sh_q[6:0], rx_din[0]};
    endcase
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      qe_s1_q  <= 1'b0;
      qe_s2_q  <= 1'b0;
      rxl_s1_q <= LANE_X1;
      rxl_s2_q <= LANE_X1;
      txl_s1_q <= LANE_OFF;
      txl_s2_q <= LANE_OFF;
    end else begin
      qe_s1_q  <= quad_enable_bit;
      qe_s2_q  <= qe_s1_q;
      rxl_s1_q <= rx_lanes;
      rxl_s2_q <= (rxl_s1_q == LANE_X4 && !qe_s1_q) ? LANE_X2 : rxl_s1_q;
      txl_s1_q <= tx_lanes;
      txl_s2_q <= (txl_s1_q == LANE_X4 && !qe_s1_q) ? LANE_X2 : txl_s1_q;
    end
  end

  // Select high clears the bit position, so either clock idle level works.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rx_sh_q  <= 8'h00;
      rx_cnt_q <= 4'h0;
    end else if (!hold_now && rxl_s2_q != LANE_OFF) begin
      rx_sh_q  <= rx_sh_d;
      rx_cnt_q <= rx_done ? 4'h0 : rx_sum;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_q <= 8'h00;
      rx_tgl_q  <= 1'b0;
    end else if (!cs_n && !hold_now && rxl_s2_q != LANE_OFF && rx_done) begin
      rx_byte_q <= rx_sh_d;
      rx_tgl_q  <= ~rx_tgl_q;
    end
  end

  // Serial clock domain, falling edge: transmit shifter and pin drivers.
  logic       put_q;
  logic       put_s1_q;
  logic       put_s2_q;
  logic       take_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] pin_q;
  logic [3:0] oe_q;
  logic [7:0] tx_hold_q;

  wire [3:0]  tx_n = lane_bits(txl_s2_q);
  wire        tx_run = (txl_s2_q != LANE_OFF) && !hold_now;
  wire        tx_load = (tx_cnt_q == 4'h0);
  wire        tx_new = tx_load && (put_s2_q != take_q);
  wire [3:0]  tx_sum = tx_cnt_q + tx_n;
  logic [7:0] tx_sh_d;
  logic [3:0] pin_d;

  always_comb begin
    if (tx_load) begin
      tx_sh_d = tx_new ? tx_hold_q : TX_IDLE_BYTE;
    end else begin
      tx_sh_d = tx_sh_q << tx_n;
    end
    case (txl_s2_q)
      LANE_X2: pin_d = {2'h0, tx_sh_d[7:6]};
      LANE_X4: pin_d = tx_sh_d[7:4];
      default: pin_d = {2'h0, tx_sh_d[7], 1'b0};
    endcase
  end

  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      put_s1_q <= 1'b0;
      put_s2_q <= 1'b0;
      take_q   <= 1'b0;
    end else begin
      put_s1_q <= put_q;
      put_s2_q <= put_s1_q;
      if (!cs_n && tx_run && tx_new) begin
        take_q <= ~take_q;
      end
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= 4'h0;
      pin_q    <= 4'h0;
      oe_q     <= 4'h0;
    end else if (tx_run) begin
      tx_sh_q  <= tx_sh_d;
      tx_cnt_q <= tx_load ? tx_n : ((tx_sum == BYTE_BITS) ? 4'h0 : tx_sum);
      pin_q    <= pin_d;
      oe_q     <= lane_oe(txl_s2_q);
    end else if (txl_s2_q == LANE_OFF) begin
      oe_q     <= 4'h0;
    end
  end

  // Hold floats the pins at once; the bit position is kept for the resume.
  wire [3:0] oe_live = oe_q & {4{~hold_now & ~cs_n}};

  assign data_line_zero_o   = pin_q[0];
  assign data_line_one_o    = pin_q[1];
  assign data_line_two_o    = pin_q[2];
  assign data_line_three_o  = pin_q[3];
  assign data_line_zero_oe  = oe_live[0];
  assign data_line_one_oe   = oe_live[1];
  assign data_line_two_oe   = oe_live[2];
  assign data_line_three_oe = oe_live[3];

  // Reference clock domain: pin synchronisers and toggle receivers.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic rxt_s1_q;
  logic rxt_s2_q;
  logic rxt_s3_q;
  logic take_s1_q;
  logic take_s2_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      wp_s1_q   <= 1'b1;
      wp_s2_q   <= 1'b1;
      rxt_s1_q  <= 1'b0;
      rxt_s2_q  <= 1'b0;
      rxt_s3_q  <= 1'b0;
      take_s1_q <= 1'b0;
      take_s2_q <= 1'b0;
    end else begin
      cs_s1_q   <= cs_n;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      wp_s1_q   <= data_line_two_i;
      wp_s2_q   <= wp_s1_q;
      rxt_s1_q  <= rx_tgl_q;
      rxt_s2_q  <= rxt_s1_q;
      rxt_s3_q  <= rxt_s2_q;
      take_s1_q <= take_q;
      take_s2_q <= take_s1_q;
    end
  end

  wire cs_fall = cs_s3_q & ~cs_s2_q;
  wire cs_rise = ~cs_s3_q & cs_s2_q;
  wire rx_evt  = rxt_s3_q ^ rxt_s2_q;

  // Frame state: armed after reset until the first select fall.
  frame_e st_q;
  frame_e st_d;

  always_comb begin
    case (st_q)
      FR_ARM:  st_d = cs_fall ? FR_SEL : FR_ARM;
      FR_IDLE: st_d = cs_fall ? FR_SEL : FR_IDLE;
      FR_SEL:  st_d = cs_rise ? FR_IDLE : FR_SEL;
      default: st_d = FR_ARM;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q        <= FR_ARM;
      standby     <= 1'b0;
      selected    <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      st_q        <= st_d;
      standby     <= cs_s2_q & ~int_busy;
      selected    <= (st_d == FR_SEL);
      frame_start <= cs_fall && st_q != FR_SEL;
    end
  end

  // Two-entry receive buffer: output register plus one skid entry.
  logic [7:0] skid_q;
  logic       skid_v_q;

  wire in_v    = rx_evt && (st_q == FR_SEL);
  wire in_fire = in_v & rx_buf_ready;
  wire pop     = rx_valid & rx_ready;
  wire out_free = ~rx_valid | pop;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_data      <= 8'h00;
      rx_valid     <= 1'b0;
      skid_q       <= 8'h00;
      skid_v_q     <= 1'b0;
      rx_buf_ready <= 1'b1;
      rx_overrun   <= 1'b0;
    end else begin
      if (out_free && skid_v_q) begin
        rx_data  <= skid_q;
        rx_valid <= 1'b1;
        skid_q   <= rxt_s3_q ? rx_byte_q : rx_byte_q;
        skid_v_q <= in_fire;
      end else if (out_free) begin
        rx_data  <= rx_byte_q;
        rx_valid <= in_fire;
      end else if (in_fire) begin
        skid_q   <= rx_byte_q;
        skid_v_q <= 1'b1;
      end
      rx_buf_ready <= out_free ? 1'b1 : ~(skid_v_q | in_fire);
      if (in_v && !rx_buf_ready) begin
        rx_overrun <= 1'b1;
      end else if (cs_fall) begin
        rx_overrun <= 1'b0;
      end
    end
  end

  // Transmit handoff: a word is held until the link side flips take.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_hold_q <= TX_IDLE_BYTE;
      put_q     <= 1'b0;
      tx_ready  <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      tx_hold_q <= tx_data;
      put_q     <= ~put_q;
      tx_ready  <= 1'b0;
    end else if (!tx_ready && take_s2_q == put_q) begin
      tx_ready  <= 1'b1;
    end
  end

  // Hardware protection from the protect pin, off while quad is enabled.
  wire wp_active = ~quad_enable_bit & ~wp_s2_q;
  wire sr_locked = (status_protect_bits == SRP_HW_LOCK) & wp_active;
  wire bp_any = sector_granularity_bit | top_bottom_select | block_protect_msb
              | block_protect_mid | block_protect_lsb;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_write_ok <= 1'b1;
      array_hw_lock   <= 1'b0;
    end else begin
      status_write_ok <= ~sr_locked;
      array_hw_lock   <= sr_locked & bp_any;
    end
  end

  // Page program column and erase region arithmetic.
  wire [23:0] span = erase_span(erase_kind);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      erase_base <= 24'h000000;
      erase_last <= 24'h000000;
      prog_addr  <= 24'h000000;
      prog_count <= 9'h000;
    end else begin
      if (erase_go) begin
        erase_base <= addr_in & ~span;
        erase_last <= addr_in | span;
      end
      if (prog_go) begin
        prog_addr  <= addr_in;
        prog_count <= 9'h000;
      end else if (prog_byte) begin
        prog_addr  <= {prog_addr[23:8], prog_addr[7:0] + 8'h01};
        if (prog_count != PAGE_FULL) begin
          prog_count <= prog_count + 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/flash_pin_front_sva.sv]
// Port-level assertions for the flash pin front end.
`timescale 1ns/1ps
`default_nettype none
module flash_pin_front_sva
  import flash_pins_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       data_line_zero_o,
  input wire logic       data_line_zero_oe,
  input wire logic       data_line_one_o,
  input wire logic       data_line_one_oe,
  input wire logic       data_line_two_i,
  input wire logic       data_line_two_oe,
  input wire logic       data_line_three_i,
  input wire logic       data_line_three_oe,
  input wire logic       quad_enable_bit,
  input wire logic [1:0] status_protect_bits,
  input wire logic       int_busy,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       standby,
  input wire logic       status_write_ok
);
  logic oe_any;
  logic hw_lock;
  assign oe_any = data_line_zero_oe | data_line_one_oe | data_line_two_oe | data_line_three_oe;
  assign hw_lock = !quad_enable_bit && status_protect_bits == SRP_HW_LOCK && !data_line_two_i;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_cs_float: assert property (cs_n |-> !oe_any) else $error("drive while deselected");
  a_hold_float: assert property (!quad_enable_bit && !data_line_three_i |-> !(data_line_zero_oe | data_line_one_oe)) else $error("drive during hold");
  a_one_falls: assert property (!cs_n && data_line_one_oe && $changed(data_line_one_o) |-> !sck) else $error("line one moved off falling edge");
  a_zero_falls: assert property (!cs_n && data_line_zero_oe && $changed(data_line_zero_o) |-> !sck) else $error("line zero moved off falling edge");
  a_standby_on: assert property ((cs_n && !int_busy) [*5] |-> standby) else $error("no standby");
  a_standby_off: assert property ((!cs_n) [*5] |-> !standby) else $error("standby while selected");
  a_rx_stands: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("byte lost before pop");
  a_wp_lock: assert property (hw_lock [*5] |-> !status_write_ok) else $error("protect pin ignored");
  a_qe_unlock: assert property (quad_enable_bit [*5] |-> status_write_ok) else $error("protect active in quad");
endmodule
`default_nettype wire

// [sim/flash_host.sv]
// Behavioural host controller driving select, serial clock and line zero.
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  output logic            sck,
  output logic            cs_n,
  output logic            h_d0,
  output logic            h_oe,
  input  wire logic [3:0] lines
);
  logic mode3;
  // Select sits low through power-up, so the first bits must be dropped.
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    h_d0 = 1'b0;
    h_oe = 1'b1;
    mode3 = 1'b0;
  end
  task automatic open_frame(input logic m3);
    mode3 = m3;
    sck = m3;
    #40 cs_n = 1'b0;
    #40;
  endtask
  task automatic xbyte(input int w, input logic [7:0] dout, output logic [7:0] din);
    h_oe = w == 1;
    din = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      sck = 1'b0;
      h_d0 = dout[7 - i];
      #32 sck = 1'b1;
      din = w == 1 ? {din[6:0], lines[1]} : w == 2 ? {din[5:0], lines[1:0]} : {din[3:0], lines};
      #32;
    end
  endtask
  task automatic close_frame();
    #32 sck = mode3;
    #32 cs_n = 1'b1;
    h_d0 = ~h_d0;
    h_oe = 1'b1;
    // Stray clocks and data while deselected must shift nothing in.
    repeat (8) begin
      #32 sck = ~sck;
      h_d0 = ~h_d0;
    end
    #100;
  endtask
endmodule
`default_nettype wire

// [sim/tb_flash_pin_front.sv]
// Self-checking bench for the flash pin front end.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_pin_front;
  import flash_pins_pkg::*;
  logic ref_clk, rst_n, quad_enable_bit, sector_granularity_bit, top_bottom_select, int_busy;
  logic block_protect_msb, block_protect_mid, block_protect_lsb, rx_ready, tx_valid, erase_go;
  logic prog_go, prog_byte, wp_n, hold_n, tick, stall, skip, rdy_d, sck, cs_n, h_d0, h_oe;
  logic rx_valid, rx_buf_ready, rx_overrun, tx_ready, standby, selected, frame_start;
  logic status_write_ok, array_hw_lock, data_line_zero_o, data_line_zero_oe, data_line_one_o;
  logic data_line_one_oe, data_line_two_o, data_line_two_oe, data_line_three_o;
  logic data_line_three_oe, data_line_zero_i, data_line_one_i, data_line_two_i;
  logic data_line_three_i;
  logic [1:0] status_protect_bits;
  logic [7:0] tx_data, rx_data, a;
  logic [8:0] prog_count;
  logic [23:0] addr_in, erase_base, erase_last, prog_addr;
  logic [23:0] span [4] = '{SPAN_4K, SPAN_32K, SPAN_64K, SPAN_CHIP};
  lanes_e rx_lanes, tx_lanes;
  erase_e erase_kind;
  int error_cnt, n_tests, cycles, seed;
  int rxq[$];
  flash_pin_front u_flash_pin_front (.*);
  flash_host u_flash_host (.sck(sck), .cs_n(cs_n), .h_d0(h_d0), .h_oe(h_oe),
    .lines({data_line_three_i, data_line_two_i, data_line_one_i, data_line_zero_i}));
  // Released lines carry a toggling pattern so a stale value never reads as good.
  assign data_line_zero_i = data_line_zero_oe ? data_line_zero_o : (h_oe ? h_d0 : tick);
  assign data_line_one_i = data_line_one_oe ? data_line_one_o : tick;
  assign data_line_two_i = data_line_two_oe ? data_line_two_o : (quad_enable_bit ? tick : wp_n);
  assign data_line_three_i = data_line_three_oe ? data_line_three_o : (quad_enable_bit ? tick : hold_n);
  always #10 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic frame(input int w, input int n, input logic m3, input int rx, input logic tx,
                       input logic [7:0] t0);
    logic [7:0] b;
    logic [7:0] r;
    u_flash_host.open_frame(m3);
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      u_flash_host.xbyte(w, b, r);
      if (i < rx)
        rxq.push_back(b);
      if (tx)
        check({24'h0, r}, {24'h0, i == 0 ? t0 : TX_IDLE_BYTE});
    end
    u_flash_host.close_frame();
  endtask
  // Model side: every byte popped while skip is low must be the oldest byte the host sent.
  always @(posedge ref_clk) begin
    tick <= ~tick;
    cycles <= cycles + 1;
    if (rst_n && rx_valid && rx_ready && !skip)
      check({24'h0, rx_data}, rxq.size() > 0 ? rxq.pop_front() : 32'hdead);
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
    rdy_d = !stall && ($random(seed) % 2 != 0);
    #1 rx_ready = rdy_d;
  end
  initial begin
    seed = 32'h36b0d608;
    {ref_clk, tick, rst_n, stall, skip, rx_ready, quad_enable_bit, int_busy, tx_valid} = '0;
    {erase_go, prog_go, prog_byte, cycles, error_cnt, n_tests, wp_n, hold_n} = 2'h3;
    {tx_data, addr_in, status_protect_bits} = '0;
    {erase_kind, rx_lanes, tx_lanes} = {ERASE_4K, LANE_X1, LANE_OFF};
    {sector_granularity_bit, top_bottom_select, block_protect_msb, block_protect_mid,
     block_protect_lsb} = 5'($random(seed));
    step(2);
    rst_n = 1'b1;
    step(6);
    check(standby, 32'h0);
    u_flash_host.xbyte(1, 8'ha5, a);
    u_flash_host.close_frame();
    check(standby, 32'h1);
    step(1);
    int_busy = 1'b1;
    step(6);
    check(standby, 32'h0);
    int_busy = 1'b0;
    for (int i = 0; i < 6; i++) frame(1, 1 + i % 3, i[0], 1 + i % 3, 1'b0, 8'h00);
    stall = 1'b1;
    frame(1, 3, 1'b0, 2, 1'b0, 8'h00);
    step(12);
    check({rx_overrun, rx_buf_ready}, 32'h2);
    stall = 1'b0;
    hold_n = 1'b0;
    step(20);
    hold_n = 1'b1;
    check(rx_valid, 32'h0);
    for (int k = 1; k < 4; k++) begin
      tx_lanes = lanes_e'(k);
      rx_lanes = k == 1 ? LANE_X1 : LANE_OFF;
      quad_enable_bit = k == 3;
      skip = 1'b1;
      frame(1, 1, 1'b1, 0, 1'b0, 8'h00);
      step(20);
      skip = 1'b0;
      a = 8'($random(seed));
      {tx_data, tx_valid} = {a, 1'b1};
      step(1);
      tx_valid = 1'b0;
      step(4);
      check(tx_ready, 32'h0);
      // Idle clocks with select high carry the put toggle into the link domain.
      u_flash_host.close_frame();
      frame(k == 3 ? 4 : k, 2, 1'b1, k == 1 ? 2 : 0, 1'b1, a);
    end
    {status_protect_bits, wp_n} = {SRP_HW_LOCK, 1'b0};
    step(6);
    check(status_write_ok, 32'h1);
    quad_enable_bit = 1'b0;
    step(6);
    check(status_write_ok, 32'h0);
    wp_n = 1'b1;
    step(6);
    check(status_write_ok, 32'h1);
    for (int k = 0; k < 4; k++) begin
      {addr_in, erase_kind, erase_go} = {24'($random(seed)), erase_e'(k), 1'b1};
      step(1);
      erase_go = 1'b0;
      step(1);
      check(erase_base, addr_in & ~span[k]);
      check(erase_last, addr_in | span[k]);
    end
    for (int n = 1; n < 300; n += 256) begin
      {addr_in, prog_go} = {16'($random(seed)), 8'hfe, 1'b1};
      step(1);
      prog_go = 1'b0;
      repeat (n) begin
        prog_byte = 1'b1;
        step(1);
        prog_byte = 1'b0;
        step(1);
      end
      check(prog_count, n > 256 ? 256 : n);
      check(prog_addr, {addr_in[23:8], 8'(8'hfe + n)});
    end
    finish_test();
  end
endmodule
bind flash_pin_front flash_pin_front_sva u_flash_pin_front_sva (.*);
`default_nettype wire
